/* core/hdil_cfg.svh */
// Register offsets, field positions and timing constants of the event block
`ifndef HDIL_CFG_SVH
`define HDIL_CFG_SVH

// System clock rate in kHz
`define HDIL_CLK_KHZ      10000
// Shortest debounce intervals, headset and button
`define HDIL_HS_DEB_MS    32
`define HDIL_BTN_DEB_MS   8
// Longest selector steps: 32 ms << 4 = 512 ms, 8 ms << 2 = 32 ms
`define HDIL_HS_SEL_MAX   3'h4
`define HDIL_BTN_SEL_MAX  2'h2
// Interrupt pulse width in microseconds and in cycles (rounded up)
`define HDIL_PULSE_US     2
`define HDIL_PULSE_CYC    ((`HDIL_PULSE_US*`HDIL_CLK_KHZ+999)/1000)

// Register offsets
`define HDIL_A_STICKY     8'h2C
`define HDIL_A_STICKY2    8'h2D
`define HDIL_A_LIVE       8'h2E
`define HDIL_A_IRQ1       8'h30
`define HDIL_A_IRQ2       8'h31
`define HDIL_A_STICKY3    8'h32
`define HDIL_A_ROUTE      8'h33
`define HDIL_A_JACK       8'h43

// Jack configuration fields
`define HDIL_JK_EN        1
`define HDIL_JK_HS_LO     2
`define HDIL_JK_TYPE_LO   5
// Interrupt control: bit 0 selects pulse train when set
`define HDIL_IC_TRAIN     0
`define HDIL_RST_BYTE     8'h00

`endif

/* core/hdil_pkg.sv */
// Types shared by the headset detect and interrupt logic
package hdil_pkg;

  // Pulse generator state of one interrupt line
  typedef enum logic [1:0] {
    HDIL_IDLE = 2'b00,
    HDIL_HIGH = 2'b01,
    HDIL_LOW  = 2'b10
  } hdil_pulse_t;

endpackage : hdil_pkg

/* core/hdil_debounce.sv */
// Pin synchroniser and debounce counter for one sensed contact
`timescale 1ns/1ps
module hdil_debounce import hdil_pkg::*; #(
  parameter int unsigned CW = 23
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // Sensed pin and control
  input  wire logic          raw,
  input  wire logic          en,
  input  wire logic [CW-1:0] limit,
  // Debounced result
  output logic               level,
  output logic               change
);

  typedef struct packed {
    logic          s1;
    logic          s2;
    logic          stable;
    logic          chg;
    logic [CW-1:0] cnt;
  } hdil_deb_t;

  hdil_deb_t s;
  hdil_deb_t next_s;

  // Count while the synced pin differs from the stable level
  always_comb begin
    next_s     = s;
    next_s.s1  = raw;
    next_s.s2  = s.s1;
    next_s.chg = 1'b0;
    if (!en) begin
      next_s.cnt    = '0;
      next_s.stable = s.s2;
    end else if (s.s2 == s.stable) begin
      next_s.cnt = '0;
    end else if (s.cnt >= limit - CW'(1)) begin
      next_s.cnt    = '0;
      next_s.stable = s.s2;
      next_s.chg    = 1'b1;
    end else begin
      next_s.cnt = s.cnt + CW'(1);
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level  = s.stable;
  assign change = s.chg;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_deb_full_wait: assert property (
    change |-> $past(s.cnt) >= $past(limit) - CW'(1))
    else $error("debounce fired before the interval ran out");
  a_deb_glitch_restart: assert property (
    en && s.s2 == s.stable |=> s.cnt == '0 && !s.chg)
    else $error("debounce count not restarted on a glitch");

endmodule : hdil_debounce

/* core/hdil_top.sv */
// Headset detection, event flags and interrupt pulse logic
//
// Notes on behaviour
// - Headset detection runs only while jack config bit D1 is set.
// - Headset debounce 32 ms to 512 ms, selected by jack config D4-D2.
// - Button debounce selected by jack config D1-D0, so 32 ms whenever D1 enables detection.
// - Live status D5-D4 show current button and headset state.
// - Sticky flag D5 sets on each debounced button press.
// - Sticky flag D4 sets on each debounced insertion or removal.
// - Sticky flags clear only when the host reads them.
// - Jack config D6-D5 report detected headset type after detection.
// - Two interrupt lines, each with its own control register.
// - Each line fires on any enabled subset of seven event kinds.
// - Each line routes to the general pin or serial data pin.
// - Control bit D0 picks single pulse or pulse train.
// - Pulse train runs until host reads the three flag registers.
// - Compressor over-threshold sets sticky D3-D2, mirrored live.
`timescale 1ns/1ps
`include "hdil_cfg.svh"
module hdil_top import hdil_pkg::*; #(
  parameter int unsigned HS_BASE_CYC  = `HDIL_HS_DEB_MS * `HDIL_CLK_KHZ,
  parameter int unsigned BTN_BASE_CYC = `HDIL_BTN_DEB_MS * `HDIL_CLK_KHZ,
  parameter int unsigned CW           = 23
) (
  // Clock and reset
  input  wire logic       CLK_SYS,
  input  wire logic       RST_N,
  // Register port
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  // Analog jack sensing
  input  wire logic       JACK_SENSE,
  input  wire logic       BUTTON_SENSE,
  input  wire logic [1:0] HS_TYPE,
  // Events from other on-chip blocks
  input  wire logic [1:0] DRC_OVER,
  input  wire logic       AGC_NOISE,
  input  wire logic       OVERCURRENT,
  input  wire logic       OVERFLOW,
  input  wire logic       DC_READY,
  // Serial audio data and output pins
  input  wire logic       AUDIO_DOUT,
  output logic            GENERAL_PIN_ONE,
  output logic            DOUT_PIN
);

  localparam logic [7:0] PLEN = 8'(`HDIL_PULSE_CYC);
  localparam int         PW   = `HDIL_PULSE_CYC;
  localparam int         PWL  = PW - 1;

  typedef struct packed {
    logic [1:0]             t1;
    logic [1:0]             t2;
    logic [1:0]             hs_type;
    logic [4:0]             jcfg;
    logic [7:0]             ctl1;
    logic [7:0]             ctl2;
    logic [1:0]             route;
    logic [5:2]             f44;
    logic [2:0]             f45;
    logic                   f50;
    logic [1:0]             drc_prev;
    hdil_pulse_t [1:0]      ps;
    logic [1:0][7:0]        pcnt;
    logic                   gp;
    logic                   dout;
    logic [7:0]             rdata;
  } hdil_st_t;

  hdil_st_t s;
  hdil_st_t next_s;

  logic          det_en;
  logic [CW-1:0] hs_lim;
  logic [CW-1:0] btn_lim;
  logic          hs_lvl;
  logic          hs_chg;
  logic          btn_lvl;
  logic          btn_chg;
  logic          btn_press;
  logic          rd44;
  logic          rd45;
  logic          rd50;
  logic [6:0]    new_evt;
  logic [6:0]    pend;
  logic [1:0]    trig;
  logic [1:0]    pend_l;
  logic [1:0]    irq;
  logic [1:0][7:0] ctl_v;

  // Detection enable and debounce interval selection
  assign det_en  = s.jcfg[`HDIL_JK_EN];
  assign hs_lim  = CW'(HS_BASE_CYC) << ((s.jcfg[4:2] > `HDIL_HS_SEL_MAX)
                   ? `HDIL_HS_SEL_MAX : s.jcfg[4:2]);
  assign btn_lim = CW'(BTN_BASE_CYC) << ((s.jcfg[1:0] > `HDIL_BTN_SEL_MAX)
                   ? `HDIL_BTN_SEL_MAX : s.jcfg[1:0]);

  // Headset and button debouncers
  hdil_debounce #(.CW(CW)) u_hs (
    .clk    (CLK_SYS),
    .rst_n  (RST_N),
    .raw    (JACK_SENSE),
    .en     (det_en),
    .limit  (hs_lim),
    .level  (hs_lvl),
    .change (hs_chg)
  );

  hdil_debounce #(.CW(CW)) u_btn (
    .clk    (CLK_SYS),
    .rst_n  (RST_N),
    .raw    (BUTTON_SENSE),
    .en     (det_en),
    .limit  (btn_lim),
    .level  (btn_lvl),
    .change (btn_chg)
  );

  assign btn_press = btn_chg & btn_lvl;

  // Reads that clear the sticky registers
  assign rd44 = REG_RD && REG_ADDR == `HDIL_A_STICKY;
  assign rd45 = REG_RD && REG_ADDR == `HDIL_A_STICKY2;
  assign rd50 = REG_RD && REG_ADDR == `HDIL_A_STICKY3;

  // Event vector in control bit order D7..D1
  assign new_evt = {hs_chg, btn_press, |(DRC_OVER & ~s.drc_prev),
                    AGC_NOISE, OVERCURRENT, OVERFLOW, DC_READY};
  assign pend    = {s.f44[4], s.f44[5], |s.f44[3:2],
                    s.f45[0], s.f45[1], s.f45[2], s.f50};
  assign ctl_v   = {s.ctl2, s.ctl1};

  // Per-line trigger, pending and pulse level
  for (genvar i = 0; i < 2; i++) begin : g_line
    assign trig[i]   = |(new_evt & ctl_v[i][7:1]);
    assign pend_l[i] = |(pend & ctl_v[i][7:1]);
    assign irq[i]    = s.ps[i] == HDIL_HIGH;
  end

  // Next state of registers, flags and pulse generators
  always_comb begin
    next_s          = s;
    next_s.t1       = HS_TYPE;
    next_s.t2       = s.t1;
    next_s.drc_prev = DRC_OVER;
    if (hs_chg) begin
      next_s.hs_type = s.t2;
    end
    if (REG_WR) begin
      unique case (REG_ADDR)
        `HDIL_A_IRQ1:  next_s.ctl1  = REG_WDATA;
        `HDIL_A_IRQ2:  next_s.ctl2  = REG_WDATA;
        `HDIL_A_ROUTE: next_s.route = REG_WDATA[1:0];
        `HDIL_A_JACK:  next_s.jcfg  = REG_WDATA[4:0];
        default:       next_s.route = s.route;
      endcase
    end
    // Set wins over the read clear
    next_s.f44 = (rd44 ? 4'h0 : s.f44)
               | {btn_press, hs_chg, DRC_OVER};
    next_s.f45 = (rd45 ? 3'h0 : s.f45)
               | {OVERFLOW, OVERCURRENT, AGC_NOISE};
    next_s.f50 = (rd50 ? 1'b0 : s.f50) | DC_READY;
    // Read data mux
    next_s.rdata = `HDIL_RST_BYTE;
    if (REG_RD) begin
      unique case (REG_ADDR)
        `HDIL_A_STICKY:  next_s.rdata = {2'h0, s.f44, 2'h0};
        `HDIL_A_STICKY2: next_s.rdata = {5'h00, s.f45};
        `HDIL_A_LIVE:    next_s.rdata = {2'h0, btn_lvl, hs_lvl,
                                         DRC_OVER, 2'h0};
        `HDIL_A_IRQ1:    next_s.rdata = s.ctl1;
        `HDIL_A_IRQ2:    next_s.rdata = s.ctl2;
        `HDIL_A_STICKY3: next_s.rdata = {7'h00, s.f50};
        `HDIL_A_ROUTE:   next_s.rdata = {6'h00, s.route};
        `HDIL_A_JACK:    next_s.rdata = {1'b0, s.hs_type, s.jcfg};
        default:         next_s.rdata = `HDIL_RST_BYTE;
      endcase
    end
    // Pulse generators
    for (int i = 0; i < 2; i++) begin
      unique case (s.ps[i])
        HDIL_IDLE: begin
          if (trig[i]) begin
            next_s.ps[i]   = HDIL_HIGH;
            next_s.pcnt[i] = 8'h00;
          end
        end
        HDIL_HIGH: begin
          if (s.pcnt[i] == PLEN - 8'h01) begin
            next_s.pcnt[i] = 8'h00;
            next_s.ps[i]   = ctl_v[i][`HDIL_IC_TRAIN]
                           ? HDIL_LOW : HDIL_IDLE;
          end else begin
            next_s.pcnt[i] = s.pcnt[i] + 8'h01;
          end
        end
        HDIL_LOW: begin
          if (s.pcnt[i] == PLEN - 8'h01) begin
            next_s.pcnt[i] = 8'h00;
            // An event in the last low cycle must not be lost
            next_s.ps[i]   = (pend_l[i] | trig[i])
                           ? HDIL_HIGH : HDIL_IDLE;
          end else begin
            next_s.pcnt[i] = s.pcnt[i] + 8'h01;
          end
        end
        default: next_s.ps[i] = HDIL_IDLE;
      endcase
    end
    // Pin routing
    next_s.gp   = (irq[0] & ~s.route[0]) | (irq[1] & ~s.route[1]);
    next_s.dout = (|s.route) ? |(irq & s.route) : AUDIO_DOUT;
  end

  // State register
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign REG_RDATA       = s.rdata;
  assign GENERAL_PIN_ONE = s.gp;
  assign DOUT_PIN        = s.dout;

  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  a_det_enable_gate: assert property (
    !det_en |=> !hs_chg && !btn_chg)
    else $error("detection event while detection disabled");
  a_btn_flag_set: assert property (
    btn_press |=> s.f44[5])
    else $error("button press did not set its flag");
  a_hs_flag_set: assert property (
    hs_chg |=> s.f44[4])
    else $error("headset change did not set its flag");
  a_flag_read_clear: assert property (
    $fell(s.f44[5]) |-> $past(rd44))
    else $error("sticky flag cleared without a read");
  a_live_status_read: assert property (
    REG_RD && REG_ADDR == `HDIL_A_LIVE
    |=> REG_RDATA[5:4] == $past({btn_lvl, hs_lvl}))
    else $error("live status does not show debounced state");
  a_type_capture: assert property (
    hs_chg |=> s.hs_type == $past(s.t2))
    else $error("headset type not captured on detection");
  a_drc_flag_set: assert property (
    DRC_OVER[0] |=> s.f44[2])
    else $error("compressor flag not set");
  a_single_pulse_len: assert property (
    $rose(irq[0]) && !s.ctl1[`HDIL_IC_TRAIN]
    |-> ##PW !irq[0])
    else $error("single pulse has the wrong length");
  a_train_repeats: assert property (
    $fell(irq[1]) && $past(s.ctl2[`HDIL_IC_TRAIN]) ##PWL pend_l[1]
    |=> irq[1])
    else $error("pulse train stopped with flags still pending");
  a_route_gpio: assert property (
    irq[0] && !s.route[0] |=> GENERAL_PIN_ONE)
    else $error("line one not routed to the general pin");

endmodule : hdil_top

/* sim/hdil_host.sv */
// Host model that reaches the registers and services interrupts
`timescale 1ns/1ps
module hdil_host (
  // Clock
  input  wire logic       clk,
  // Register port
  output logic      [7:0] addr,
  output logic      [7:0] wdata,
  output logic            wr,
  output logic            rd,
  input  wire logic [7:0] rdata
);
  // Idle bus at time zero
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end

  // One write strobe; address is scrambled once the strobe is gone
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask : wr_reg

  // One read strobe; data stands only in the following cycle
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    addr = ~a;
    d = rdata;
  endtask : rd_reg

  // Read all three flag registers so a pulse train stops
  task automatic service;
    logic [7:0] d;
    rd_reg(8'h2C, d);
    rd_reg(8'h2D, d);
    rd_reg(8'h32, d);
  endtask : service
endmodule : hdil_host

/* sim/hdil_top_tb.sv */
// Self-checking bench for the headset detect and interrupt logic
`timescale 1ns/1ps
`include "hdil_cfg.svh"
module hdil_top_tb;
  // Short debounce bases keep the run brief
  localparam int HSB = 8;
  localparam int BTB = 4;
  logic       clk_sys = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       jack = 1'b0;
  logic       btn = 1'b0;
  logic [1:0] hs_type = 2'b10;
  logic [4:0] ev = 5'h00;
  logic       aud = 1'b0;
  logic       gp;
  logic       dout;
  int         err_count = 0;
  int         comparisons = 0;

  // 10 MHz clock
  always #50 clk_sys = ~clk_sys;

  hdil_top #(.HS_BASE_CYC(HSB), .BTN_BASE_CYC(BTB), .CW(23)) i_hdil_top (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .JACK_SENSE(jack), .BUTTON_SENSE(btn), .HS_TYPE(hs_type),
    .DRC_OVER({2{ev[4]}}), .AGC_NOISE(ev[3]), .OVERCURRENT(ev[2]),
    .OVERFLOW(ev[1]), .DC_READY(ev[0]), .AUDIO_DOUT(aud),
    .GENERAL_PIN_ONE(gp), .DOUT_PIN(dout));

  hdil_host i_hdil_host (.clk(clk_sys), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata));

  // Verdict and end of run
  task automatic complete_run;
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  // Compare a register byte
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: byte %h not %h", $time, got, exp);
    end
  endtask : check8

  // Compare a pulse count
  task automatic checkn(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      err_count++;
      $display("mismatch at %0t: count %0d not %0d", $time, got, exp);
    end
  endtask : checkn

  // Read a register and compare it
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_hdil_host.rd_reg(a, d);
    check8(d, exp);
  endtask : rd_chk

  // One-cycle pulse on an on-chip event input
  task automatic fire(input int k);
    @(negedge clk_sys);
    ev[k] = 1'b1;
    @(negedge clk_sys);
    ev = 5'h00;
  endtask : fire

  // Count high cycles and rising edges of a pin over n cycles
  task automatic watch(input int n, input bit sel, output int hi,
                       output int edges);
    logic p;
    logic q;
    hi = 0;
    edges = 0;
    q = 1'b0;
    repeat (n) begin
      @(negedge clk_sys);
      p = sel ? dout : gp;
      if (p === 1'b1) hi++;
      if (p === 1'b1 && q !== 1'b1) edges++;
      q = p;
    end
  endtask : watch

  // Register reset values, access kinds and the default data route
  task automatic s_regs;
    rd_chk(`HDIL_A_IRQ1, 8'h00);
    i_hdil_host.wr_reg(`HDIL_A_IRQ1, 8'hA5);
    i_hdil_host.wr_reg(`HDIL_A_IRQ2, 8'h5A);
    rd_chk(`HDIL_A_IRQ1, 8'hA5);
    rd_chk(`HDIL_A_IRQ2, 8'h5A);
    rd_chk(8'h40, 8'h00);
    i_hdil_host.wr_reg(`HDIL_A_LIVE, 8'hFF);
    rd_chk(`HDIL_A_LIVE, 8'h00);
    i_hdil_host.wr_reg(`HDIL_A_IRQ1, 8'h00);
    i_hdil_host.wr_reg(`HDIL_A_IRQ2, 8'h00);
    aud = 1'b1;
    repeat (3) @(negedge clk_sys);
    check8({7'h00, dout}, 8'h01);
  endtask : s_regs

  // Jack insertion with a glitch, then a slow removal
  task automatic s_jack;
    jack = 1'b1;
    repeat (30) @(negedge clk_sys);
    rd_chk(`HDIL_A_STICKY, 8'h00);
    jack = 1'b0;
    repeat (30) @(negedge clk_sys);
    i_hdil_host.wr_reg(`HDIL_A_JACK, 8'h02);
    jack = 1'b1;
    repeat (5) @(negedge clk_sys);
    jack = 1'b0;
    @(negedge clk_sys);
    jack = 1'b1;
    repeat (6) @(negedge clk_sys);
    rd_chk(`HDIL_A_STICKY, 8'h00);
    repeat (10) @(negedge clk_sys);
    rd_chk(`HDIL_A_STICKY, 8'h10);
    rd_chk(`HDIL_A_STICKY, 8'h00);
    rd_chk(`HDIL_A_LIVE, 8'h10);
    rd_chk(`HDIL_A_JACK, 8'h42);
    i_hdil_host.wr_reg(`HDIL_A_JACK, 8'h12);
    jack = 1'b0;
    hs_type = 2'b01;
    repeat (100) @(negedge clk_sys);
    rd_chk(`HDIL_A_STICKY, 8'h00);
    repeat (40) @(negedge clk_sys);
    rd_chk(`HDIL_A_STICKY, 8'h10);
    rd_chk(`HDIL_A_LIVE, 8'h00);
    rd_chk(`HDIL_A_JACK, 8'h32);
  endtask : s_jack

  // Button press at the longest button interval, then release
  task automatic s_button;
    i_hdil_host.wr_reg(`HDIL_A_JACK, 8'h02);
    btn = 1'b1;
    repeat (12) @(negedge clk_sys);
    rd_chk(`HDIL_A_STICKY, 8'h00);
    repeat (8) @(negedge clk_sys);
    rd_chk(`HDIL_A_STICKY, 8'h20);
    rd_chk(`HDIL_A_LIVE, 8'h20);
    btn = 1'b0;
    repeat (25) @(negedge clk_sys);
    rd_chk(`HDIL_A_STICKY, 8'h00);
  endtask : s_button

  // Compressor over threshold, live and sticky
  task automatic s_drc;
    ev[4] = 1'b1;
    repeat (3) @(negedge clk_sys);
    rd_chk(`HDIL_A_LIVE, 8'h0C);
    ev[4] = 1'b0;
    rd_chk(`HDIL_A_STICKY, 8'h0C);
    rd_chk(`HDIL_A_STICKY, 8'h00);
    fire(0);
    rd_chk(`HDIL_A_STICKY3, 8'h01);
    rd_chk(`HDIL_A_STICKY3, 8'h00);
  endtask : s_drc

  // Single pulses on line one for each on-chip event, one masked event
  task automatic s_single;
    int hi;
    int ed;
    i_hdil_host.wr_reg(`HDIL_A_ROUTE, 8'h00);
    for (int k = 0; k < 5; k++) begin
      i_hdil_host.wr_reg(`HDIL_A_IRQ1, 8'h02 << k);
      fire(k);
      watch(60, 1'b0, hi, ed);
      checkn(hi, `HDIL_PULSE_CYC);
      checkn(ed, 1);
      i_hdil_host.service;
    end
    i_hdil_host.wr_reg(`HDIL_A_IRQ1, 8'h02);
    fire(1);
    watch(60, 1'b0, hi, ed);
    checkn(hi, 0);
    rd_chk(`HDIL_A_STICKY2, 8'h04);
    rd_chk(`HDIL_A_STICKY2, 8'h00);
    i_hdil_host.service;
  endtask : s_single

  // Pulse train on line two routed to the data pin until serviced
  task automatic s_train;
    int hi;
    int ed;
    i_hdil_host.wr_reg(`HDIL_A_IRQ2, 8'h11);
    i_hdil_host.wr_reg(`HDIL_A_ROUTE, 8'h02);
    fire(3);
    watch(100, 1'b1, hi, ed);
    checkn(ed, 3);
    i_hdil_host.service;
    repeat (45) @(negedge clk_sys);
    watch(100, 1'b1, hi, ed);
    checkn(hi, 0);
  endtask : s_train

  // Main sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    s_regs;
    s_jack;
    s_button;
    s_drc;
    s_single;
    s_train;
    complete_run;
  end

  // Cut a hang short
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    $display("mismatch at %0t: run did not end in time", $time);
    complete_run;
  end
endmodule : hdil_top_tb
